// file: inc/cdc_pkg.sv
package cdc_pkg;
	// ==========================================================
	// Register map
	localparam logic [1:0] CDC_ADDR_CTRL0  = 2'h0;
	localparam logic [1:0] CDC_ADDR_CTRL1  = 2'h1;
	localparam logic [1:0] CDC_ADDR_MIRROR = 2'h2;
	localparam logic [1:0] CDC_ADDR_FLAG   = 2'h3;
	// ==========================================================
	// Field positions, control register 0
	localparam int CDC_C0_ENABLE = 7;
	localparam int CDC_C0_RESULT = 6;
	localparam int CDC_C0_PINOE  = 5;
	localparam int CDC_C0_INVERT = 4;
	localparam int CDC_C0_SPEED  = 2;
	localparam int CDC_C0_HYST   = 1;
	localparam int CDC_C0_SYNC   = 0;
	// Field positions, control register 1
	localparam int CDC_C1_RISE   = 7;
	localparam int CDC_C1_FALL   = 6;
	localparam int CDC_C1_PCH_LO = 4;
	localparam int CDC_C1_NCH_LO = 0;
	// Flag register
	localparam int CDC_FLAG_BIT  = 0;
	// ==========================================================
	// Reset values
	localparam logic [7:0] CDC_CTRL0_RST = 8'h04;
	localparam logic [7:0] CDC_CTRL1_RST = 8'h00;
	// Writable masks
	localparam logic [7:0] CDC_CTRL0_WMASK = 8'hb7;
	localparam logic [7:0] CDC_CTRL1_WMASK = 8'hf7;
	// ==========================================================
	// Positive channel codes
	localparam logic [1:0] CDC_PCH_PIN = 2'h0;
	localparam logic [1:0] CDC_PCH_DAC = 2'h1;
	localparam logic [1:0] CDC_PCH_FVR = 2'h2;
	localparam logic [1:0] CDC_PCH_GND = 2'h3;
	// Negative channel codes
	localparam logic [2:0] CDC_NCH_PIN_A = 3'h0;
	localparam logic [2:0] CDC_NCH_PIN_B = 3'h1;
	localparam logic [2:0] CDC_NCH_FVR   = 3'h4;

	typedef struct packed {
		logic       enable;
		logic       hyst;
		logic       speed;
		logic [3:0] pos_onehot;
		logic [2:0] neg_onehot;
	} cdc_analog_s;
endpackage

// file: testbench/cdc_timer_model.sv
// ==========================================
// Timer side: clocks stand high between pulses
module cdc_timer_model (
	input  wire logic mclk_i,
	output logic      timer_clk_o,
	output logic      prescaler_clk_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned count = 0;
	initial begin
		timer_clk_o = 1'b1;
		prescaler_clk_o = 1'b1;
	end
	// Count on rising edge only, so latching on falling never races
	always @(posedge timer_clk_o) count <= count + 1;
	task automatic pulse(input bit pre);
		repeat (4) @(posedge mclk_i);
		if (pre) prescaler_clk_o <= 1'b0; else timer_clk_o <= 1'b0;
		repeat (4) @(posedge mclk_i);
		prescaler_clk_o <= 1'b1;
		timer_clk_o <= 1'b1;
	endtask
endmodule

// file: testbench/tb_top.sv
module tb_top
	import cdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0;
	logic [1:0]  addr_i = 0;
	logic [7:0]  wdata_i = 0, rdata_o, v;
	logic        raw = 0, dir = 1, pre = 0, tclk, pclk;
	logic        timer_cmp_o, pin_out_o, pin_oe_o, flag;
	cdc_analog_s analog_o;
	int          err_count = 0, n_tests = 0, p, n;
	always #20 mclk_i = ~mclk_i;
	cdc_timer_model tm_u (.mclk_i(mclk_i), .timer_clk_o(tclk), .prescaler_clk_o(pclk));
	cdc_comparator_ctrl dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_raw_i(raw),
		.timer_clk_i(tclk), .prescaler_clk_i(pclk), .prescaler_used_i(pre),
		.pin_direction_i(dir), .analog_o(analog_o), .timer_cmp_o(timer_cmp_o),
		.pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .cmp_irq_flag_o(flag));
	// ==========================================
	// Checks and bus cycles
	function automatic logic [2:0] neg_exp(input int c);
		return (c == 0) ? 3'h1 : (c == 1) ? 3'h2 : (c == 4) ? 3'h4 : 3'h0;
	endfunction
	task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge mclk_i);
		#1;
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk("rdata", rdata_o, e);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#400000 err_count++;
		conclude();
	end
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h0c2a));
		wt(4);
		sys_rst_i <= 1'b0;
		wt(1);
		chk("speed", analog_o.speed, 1);
		rd(CDC_ADDR_CTRL0, CDC_CTRL0_RST);
		rd(CDC_ADDR_CTRL1, 8'h00);
		rd(CDC_ADDR_FLAG, 8'h00);
		wr(CDC_ADDR_CTRL1, 8'h80);
		wr(CDC_ADDR_CTRL0, 8'h10);
		wt(30);
		chk("flag", flag, 1);
		rd(CDC_ADDR_CTRL0, 8'h50);
		rd(CDC_ADDR_MIRROR, 8'h01);
		wr(CDC_ADDR_FLAG, 8'h00);
		wt(2);
		chk("flag", flag, 0);
		wr(CDC_ADDR_CTRL0, 8'h00);
		wt(8);
		chk("flag", flag, 0);
		wr(CDC_ADDR_CTRL0, 8'h10);
		wr(CDC_ADDR_FLAG, 8'h00);
		wt(2);
		chk("flag", flag, 1);
		wr(CDC_ADDR_FLAG, 8'h00);
		wr(CDC_ADDR_CTRL1, 8'h40);
		wr(CDC_ADDR_CTRL0, 8'h00);
		wt(4);
		chk("flag", flag, 1);
		wr(CDC_ADDR_CTRL0, 8'ha6);
		for (int i = 0; i < 8; i++) begin
			raw <= $urandom;
			dir <= $urandom;
			wt(8);
			chk("timer", timer_cmp_o, raw);
			chk("pin", pin_out_o, raw);
			chk("oe", pin_oe_o, !dir);
			chk("hyst", analog_o.hyst, 1);
			chk("en", analog_o.enable, 1);
			p = i % 4;
			n = $urandom % 8;
			wr(CDC_ADDR_CTRL1, 8'((p << 4) | n));
			wt(3);
			chk("pos", analog_o.pos_onehot, 4'h1 << p);
			chk("neg", analog_o.neg_onehot, neg_exp(n));
		end
		wr(CDC_ADDR_CTRL0, 8'h26);
		wt(3);
		v = {analog_o.pos_onehot, 1'b0, analog_o.neg_onehot};
		chk("off", v, 8'h00);
		wr(CDC_ADDR_CTRL0, 8'h81);
		raw <= 1'b0;
		tm_u.pulse(0);
		raw <= 1'b1;
		wt(10);
		chk("hold", timer_cmp_o, 0);
		tm_u.pulse(0);
		wt(10);
		chk("latch", timer_cmp_o, 1);
		chk("pin", pin_out_o, 1);
		pre <= 1'b1;
		raw <= 1'b0;
		tm_u.pulse(0);
		wt(10);
		chk("pre", timer_cmp_o, 1);
		tm_u.pulse(1);
		wt(10);
		chk("pre", timer_cmp_o, 0);
		conclude();
	end
endmodule

// file: verilog/cdc_comparator_ctrl.sv
// Functional notes
// - Sync mode latches result on timer falling edge
// - Falling edge taken from prescaler output when prescaler in use, else from timer clock
// - Timer counts rising, latch on falling edge
// - Sync clear passes result straight through
// - Separate rise/fall detectors set enabled flag
// - Flag stays set until software clears
// - Set beats simultaneous software clear
// - Invert toggles count as edges, enable toggles only while raw compare is high
// - Result is compare, inverted when invert set
// - Pin out enable overrides latch, needs direction
// - Positive select: pin, DAC, FIXED_VOLTAGE_REF, ground
// - Negative select: pin A, pin B, FIXED_VOLTAGE_REF
// - Speed bit resets to one
// - Hysteresis bit commands analog hysteresis
// - Enable bit powers comparator, resets zero
// - Mirror register bit 0 is result
// - Internal result registered every cycle
// - Disabled comparator disconnects all inputs
module cdc_comparator_ctrl
	import cdc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [1:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        cmp_raw_i,
	input  wire logic        timer_clk_i,
	input  wire logic        prescaler_clk_i,
	input  wire logic        prescaler_used_i,
	input  wire logic        pin_direction_i,
	output cdc_analog_s      analog_o,
	output logic             timer_cmp_o,
	output logic             pin_out_o,
	output logic             pin_oe_o,
	output logic             cmp_irq_flag_o
);
	// ==========================================================
	// Input synchronisers
	logic [1:0] raw_sync;
	logic [1:0] tclk_sync;
	logic [1:0] pclk_sync;
	logic       tsrc_prev;
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			raw_sync  <= 2'h0;
			tclk_sync <= 2'h0;
			pclk_sync <= 2'h0;
		end else begin
			raw_sync  <= {raw_sync[0], cmp_raw_i};
			tclk_sync <= {tclk_sync[0], timer_clk_i};
			pclk_sync <= {pclk_sync[0], prescaler_clk_i};
		end
	end

	// ==========================================================
	// Registers
	logic [7:0] ctrl0;
	logic [7:0] ctrl1;
	logic       cmp_irq_flag;
	logic       cmp_result;
	logic       result_prev;
	logic       sync_latch;

	wire cmp_enable       = ctrl0[CDC_C0_ENABLE];
	wire cmp_pin_out_enable = ctrl0[CDC_C0_PINOE];
	wire cmp_invert       = ctrl0[CDC_C0_INVERT];
	wire cmp_speed_select = ctrl0[CDC_C0_SPEED];
	wire cmp_hysteresis_on = ctrl0[CDC_C0_HYST];
	wire cmp_sync_to_timer = ctrl0[CDC_C0_SYNC];
	wire rise_edge_irq_en = ctrl1[CDC_C1_RISE];
	wire fall_edge_irq_en = ctrl1[CDC_C1_FALL];
	wire [1:0] pos_channel_sel = ctrl1[CDC_C1_PCH_LO +: 2];
	wire [2:0] neg_channel_sel = ctrl1[CDC_C1_NCH_LO +: 3];

	wire wr_ctrl0 = wr_i && (addr_i == CDC_ADDR_CTRL0);
	wire wr_ctrl1 = wr_i && (addr_i == CDC_ADDR_CTRL1);
	wire clr_flag = wr_i && (addr_i == CDC_ADDR_FLAG) && !wdata_i[CDC_FLAG_BIT];

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ctrl0 <= CDC_CTRL0_RST;
			ctrl1 <= CDC_CTRL1_RST;
		end else begin
			if (wr_ctrl0)
				ctrl0 <= wdata_i & CDC_CTRL0_WMASK;
			if (wr_ctrl1)
				ctrl1 <= wdata_i & CDC_CTRL1_WMASK;
		end
	end

	// ==========================================================
	// Result path; comparator output seen as zero when off
	wire cmp_gated   = cmp_enable & raw_sync[1];
	wire next_result = cmp_gated ^ cmp_invert;

	// Edge source: prescaler output when prescaler in use
	wire tsrc     = prescaler_used_i ? pclk_sync[1] : tclk_sync[1];
	// Latch on falling edge; the timer counts on rising, so no race
	wire tsrc_fall = tsrc_prev && !tsrc;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cmp_result  <= 1'b0;
			result_prev <= 1'b0;
			sync_latch  <= 1'b0;
			tsrc_prev   <= 1'b0;
		end else begin
			cmp_result  <= next_result;
			result_prev <= cmp_result;
			tsrc_prev   <= tsrc;
			if (tsrc_fall)
				sync_latch <= cmp_result;
		end
	end

	// ==========================================================
	// Edge detection and flag
	wire rise_seen = cmp_result && !result_prev;
	wire fall_seen = !cmp_result && result_prev;
	wire flag_set  = (rise_seen && rise_edge_irq_en) || (fall_seen && fall_edge_irq_en);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			cmp_irq_flag <= 1'b0;
		else if (flag_set)
			cmp_irq_flag <= 1'b1;
		else if (clr_flag)
			cmp_irq_flag <= 1'b0;
	end

	// ==========================================================
	// Outputs; async mode uses the single-cycle result with no timer latch
	wire next_ext = cmp_sync_to_timer ? sync_latch : cmp_result;

	wire [3:0] pos_onehot = cmp_enable ? (4'h1 << pos_channel_sel) : 4'h0;
	wire [2:0] neg_onehot = !cmp_enable ? 3'h0 :
		(neg_channel_sel == CDC_NCH_PIN_A) ? 3'h1 :
		(neg_channel_sel == CDC_NCH_PIN_B) ? 3'h2 :
		(neg_channel_sel == CDC_NCH_FVR)   ? 3'h4 : 3'h0;

	wire [7:0] rd_val =
		(addr_i == CDC_ADDR_CTRL0)  ? ((ctrl0 & CDC_CTRL0_WMASK) | {1'b0, cmp_result, 6'h00}) :
		(addr_i == CDC_ADDR_CTRL1)  ? ctrl1 :
		(addr_i == CDC_ADDR_MIRROR) ? {7'h00, cmp_result} :
		{7'h00, cmp_irq_flag};

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rdata_o        <= 8'h00;
			analog_o       <= '{enable: 1'b0, hyst: 1'b0, speed: 1'b1, pos_onehot: 4'h0, neg_onehot: 3'h0};
			timer_cmp_o    <= 1'b0;
			pin_out_o      <= 1'b0;
			pin_oe_o       <= 1'b0;
			cmp_irq_flag_o <= 1'b0;
		end else begin
			rdata_o        <= rd_i ? rd_val : 8'h00;
			analog_o       <= '{enable: cmp_enable, hyst: cmp_hysteresis_on, speed: cmp_speed_select,
				pos_onehot: pos_onehot, neg_onehot: neg_onehot};
			timer_cmp_o    <= next_ext;
			pin_out_o      <= next_ext;
			pin_oe_o       <= cmp_pin_out_enable && !pin_direction_i;
			cmp_irq_flag_o <= flag_set || (cmp_irq_flag && !clr_flag);
		end
	end

	// ==========================================================
	// Checks, flag
	sequence s_rise_event;
		$rose(cmp_result) && rise_edge_irq_en;
	endsequence

	sequence s_fall_event;
		$fell(cmp_result) && fall_edge_irq_en;
	endsequence

	sequence s_clear_request;
		wr_i && (addr_i == CDC_ADDR_FLAG) && !wdata_i[CDC_FLAG_BIT];
	endsequence

	// Clear in the edge cycle must not swallow the event
	a_flag_set_wins: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		s_clear_request ##0 flag_set |=> cmp_irq_flag)
		else $error("flag lost to clear");

	a_flag_after_edge: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		flag_set |=> cmp_irq_flag)
		else $error("flag not set after edge");

	a_flag_holds: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cmp_irq_flag && !clr_flag |=> cmp_irq_flag)
		else $error("flag dropped");

	a_flag_clears: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		s_clear_request ##0 !flag_set |=> !cmp_irq_flag)
		else $error("flag not cleared");

	a_rise_edge: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		s_rise_event |=> cmp_irq_flag)
		else $error("rise missed");

	a_fall_edge: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		s_fall_event |=> cmp_irq_flag)
		else $error("fall missed");

	a_quiet_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!cmp_irq_flag && $stable(cmp_result) |=> !cmp_irq_flag)
		else $error("flag without edge");

	a_flag_output: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |=> cmp_irq_flag_o == cmp_irq_flag)
		else $error("flag output differs");

	// No disable here: the reset itself is what is checked
	a_reset_clear: assert property (@(posedge mclk_i)
		sys_rst_i |=> !cmp_irq_flag && !result_prev && !cmp_irq_flag_o)
		else $error("flag not reset");

	a_speed_reset: assert property (@(posedge mclk_i)
		sys_rst_i |=> analog_o.speed && ctrl0[CDC_C0_SPEED])
		else $error("speed not reset");

	// ==========================================================
	// Checks, result path
	a_result_value: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |=> cmp_result == (($past(raw_sync[1]) && $past(cmp_enable)) != $past(cmp_invert)))
		else $error("result wrong");

	a_result_tracks: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$changed(raw_sync[1]) && cmp_enable && $stable(cmp_enable) && $stable(cmp_invert)
		|=> $changed(cmp_result))
		else $error("result late");

	a_invert_edge: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$changed(cmp_invert) && $stable(cmp_gated) |=> cmp_result != $past(cmp_result))
		else $error("invert no edge");

	a_enable_edge: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$changed(cmp_enable) && $stable(cmp_invert) && raw_sync[1] && $stable(raw_sync[1])
		|=> cmp_result != $past(cmp_result))
		else $error("enable no edge");

	// ==========================================================
	// Checks, timer side
	sequence s_timer_fall;
		$fell(tsrc);
	endsequence

	a_sync_latch: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		s_timer_fall |=> sync_latch == $past(cmp_result))
		else $error("latch wrong");

	a_sync_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!$fell(tsrc) |=> $stable(sync_latch))
		else $error("latch moved");

	a_sync_output: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cmp_sync_to_timer |=> timer_cmp_o == $past(sync_latch))
		else $error("sync output wrong");

	a_async_path: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!cmp_sync_to_timer |=> timer_cmp_o == $past(cmp_result))
		else $error("async wrong");

	// A rising source edge is when the timer counts
	a_rise_no_latch: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$rose(tsrc) |=> $stable(sync_latch))
		else $error("latch on rising edge");

	a_prescaler_edge: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		prescaler_used_i && $past(prescaler_used_i) |-> tsrc_fall == $fell(pclk_sync[1]))
		else $error("prescaler edge wrong");

	a_timer_edge: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!prescaler_used_i && !$past(prescaler_used_i) |-> tsrc_fall == $fell(tclk_sync[1]))
		else $error("timer edge wrong");

	// ==========================================================
	// Checks, pin
	a_pin_value: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |-> pin_out_o == timer_cmp_o)
		else $error("pin value wrong");

	a_pin_enable: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		pin_direction_i |=> !pin_oe_o)
		else $error("pin driven as input");

	a_pin_drive: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cmp_pin_out_enable && !pin_direction_i |=> pin_oe_o)
		else $error("pin not driven");

	// ==========================================================
	// Checks, analog controls
	a_inputs_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!cmp_enable |=> analog_o.pos_onehot == 4'h0 && analog_o.neg_onehot == 3'h0)
		else $error("inputs connected");

	a_pos_ground: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cmp_enable && (pos_channel_sel == CDC_PCH_GND) |=> analog_o.pos_onehot == 4'h8)
		else $error("ground select wrong");

	a_pos_reference: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cmp_enable && (pos_channel_sel == CDC_PCH_FVR) |=> analog_o.pos_onehot == 4'h4)
		else $error("positive reference wrong");

	a_neg_reference: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cmp_enable && (neg_channel_sel == CDC_NCH_FVR) |=> analog_o.neg_onehot == 3'h4)
		else $error("negative reference wrong");

	// Reserved codes connect nothing rather than a guess
	a_neg_reserved: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		neg_channel_sel[1] |=> analog_o.neg_onehot == 3'h0)
		else $error("reserved code connected");

	a_analog_bits: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |=> analog_o.hyst == $past(cmp_hysteresis_on) && analog_o.enable == $past(cmp_enable))
		else $error("analog bits wrong");

	a_speed_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |=> analog_o.speed == $past(cmp_speed_select))
		else $error("speed bit wrong");

	// ==========================================================
	// Checks, register reads
	sequence s_mirror_read;
		rd_i && (addr_i == CDC_ADDR_MIRROR);
	endsequence

	a_mirror_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		s_mirror_read |=> rdata_o == {7'h00, $past(cmp_result)})
		else $error("mirror read wrong");

	a_rdata_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data not idle");
endmodule
